// [hdl/dacsw_pkg.sv]
package dacsw_pkg;
	// frame layout
	localparam int FRAME_BITS = 24;
	localparam int CODE_BITS = 16;
	localparam int MODE_HI_POS = 17;
	localparam int MODE_LO_POS = 16;
	localparam int CODE_LSB_POS = 0;
	localparam logic [4:0] LAST_BIT_IDX = 5'h17;
	// operating modes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_PD_1K = 2'h1;
	localparam logic [1:0] MODE_PD_100K = 2'h2;
	localparam logic [1:0] MODE_PD_HIZ = 2'h3;
	// power-on codes
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MID = 16'h8000;
	// timing
	localparam int CLK_NS = 8;
	localparam int SYNC_HIGH_NS = 33;
	localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_US = 4;
	localparam int WAKE_CYC = WAKE_US * 1000 / CLK_NS;
	// host serial clock divider: half period in mclk cycles
	localparam int SCLK_HALF_CYC = 4;
endpackage

// [hdl/dacsw_if.sv]
`timescale 1ns/100ps
interface dacsw_if;
	logic sync_n;
	logic sclk;
	logic sdata;
	modport dev (input sync_n, input sclk, input sdata);
	modport host (output sync_n, output sclk, output sdata);
endinterface

// [hdl/dacsw_dev.sv]
`timescale 1ns/100ps
// Overview of operation
// - 24 falling edges with sync low apply frame
// - early sync rise clears shift register
// - aborted frame keeps code and mode
// - power-up code zero or midscale option
// - power-on code held until first valid frame
// - mode from bits 17:16, 00 normal
// - 01 1k, 10 100k, 11 high-impedance
// - power-down routes output to termination
// - power-down shuts bias, amplifier, string
// - code retained during power-down
// - host waits 4 us after wake
// - host sends msb first
// - byte hosts keep sync low across bytes
// - host data valid on falling edge
// - sync falls before first bit
// - six ignored, two mode, sixteen code bits
// - sample data on falling edge, sync low
// - sync high 33 ns between frames
module dacsw_dev
	import dacsw_pkg::*;
#(
	parameter bit POR_MIDSCALE = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// serial link
	dacsw_if.dev link,
	// converter controls
	output logic [15:0] dac_code,
	output logic [1:0] op_mode,
	output logic amp_to_output,
	output logic term_1k,
	output logic term_100k,
	output logic term_hiz,
	output logic shutdown_bias,
	output logic shutdown_amp,
	output logic shutdown_string,
	output logic frame_done,
	output logic frame_abort
);
	logic [1:0] sync_s_q, sclk_s_q, data_s_q;
	logic sclk_prev_q, sync_prev_q;
	logic [23:0] shift_q;
	logic [4:0] cnt_q;
	logic done_q; // frame executed, wait for resync
	logic fall_sclk, rise_sync, sync_low;
	logic load_frame; // 24th edge of a live frame
	logic [23:0] shift_d;

	// every pin crosses two flops before any logic reads it
	// only the second flop of each pair feeds the edge logic below

	// frame sync synchroniser; resets to idle high so no false frame start
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sync_s_q <= 2'h3;
			sync_prev_q <= 1'b1;
		end else begin
			sync_s_q <= {sync_s_q[0], link.sync_n};
			sync_prev_q <= sync_s_q[1];
		end
	end

	// serial clock synchroniser; idle level high avoids a false fall after reset
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sclk_s_q <= 2'h3;
			sclk_prev_q <= 1'b1;
		end else begin
			sclk_s_q <= {sclk_s_q[0], link.sclk};
			sclk_prev_q <= sclk_s_q[1];
		end
	end

	// data synchroniser; same depth as sclk so bit and edge stay aligned
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			data_s_q <= 2'h0;
		end else begin
			data_s_q <= {data_s_q[0], link.sdata};
		end
	end

	// edge detection on synchronised copies only
	assign fall_sclk = sclk_prev_q & ~sclk_s_q[1];
	assign rise_sync = ~sync_prev_q & sync_s_q[1];
	assign sync_low = ~sync_s_q[1];
	assign shift_d = {shift_q[22:0], data_s_q[1]};
	assign load_frame = sync_low && fall_sclk && !done_q && cnt_q == LAST_BIT_IDX;

	// shift register and bit counter
	// limitation: each sclk half period must span three mclk cycles,
	// or the synchronisers miss edges; faster hosts need a faster mclk
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			shift_q <= 24'h000000;
			cnt_q <= 5'h00;
			done_q <= 1'b0;
		end else if (!sync_low) begin
			shift_q <= 24'h000000;
			cnt_q <= 5'h00;
			done_q <= 1'b0;
		end else if (fall_sclk && !done_q) begin
			shift_q <= shift_d;
			if (cnt_q == LAST_BIT_IDX) begin
				cnt_q <= 5'h00;
				done_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	// code register loads on the 24th edge only; power-on value stands till then
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			dac_code <= POR_MIDSCALE ? CODE_MID : CODE_ZERO;
		end else if (load_frame) begin
			dac_code <= shift_d[CODE_LSB_POS +: CODE_BITS];
		end
	end

	// mode register loads with the code; power-down leaves the code alone
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			op_mode <= MODE_NORMAL;
		end else if (load_frame) begin
			op_mode <= {shift_d[MODE_HI_POS], shift_d[MODE_LO_POS]};
		end
	end
	// aborted frames never reach the loads above, so code and mode stand

	// completion pulse, one cycle, in step with the code and mode load
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			frame_done <= 1'b0;
		end else begin
			frame_done <= load_frame;
		end
	end

	// abort pulse only once a bit was taken; a bare sync blip is no frame
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			frame_abort <= 1'b0;
		end else begin
			frame_abort <= rise_sync && !done_q && cnt_q != 5'h00;
		end
	end

	// amplifier route; one cycle behind mode, harmless against the wake time
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			amp_to_output <= 1'b1;
		end else begin
			amp_to_output <= op_mode == MODE_NORMAL;
		end
	end

	// termination network, exactly one arm while powered down
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			term_1k <= 1'b0;
			term_100k <= 1'b0;
			term_hiz <= 1'b0;
		end else begin
			term_1k <= op_mode == MODE_PD_1K;
			term_100k <= op_mode == MODE_PD_100K;
			term_hiz <= op_mode == MODE_PD_HIZ;
		end
	end

	// bias generator shutdown in any power-down mode
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			shutdown_bias <= 1'b0;
		end else begin
			shutdown_bias <= op_mode != MODE_NORMAL;
		end
	end

	// amplifier shutdown; output routed away from it on the same mclk edge
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			shutdown_amp <= 1'b0;
		end else begin
			shutdown_amp <= op_mode != MODE_NORMAL;
		end
	end

	// resistor string shutdown; the code register has no clear, so it survives
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			shutdown_string <= 1'b0;
		end else begin
			shutdown_string <= op_mode != MODE_NORMAL;
		end
	end
endmodule

// [hdl/dacsw_host.sv]
`timescale 1ns/100ps
module dacsw_host
	import dacsw_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// user request
	input wire logic req_valid,
	input wire logic [1:0] req_mode,
	input wire logic [15:0] req_code,
	output logic req_ready,
	output logic out_valid,
	// serial link
	dacsw_if.host link
);
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP, ST_WAKE} dacsw_state_e;
	dacsw_state_e state_q;
	logic [23:0] frame_q;
	logic [4:0] bit_q;
	logic [2:0] div_q;
	logic [9:0] wait_q;
	logic phase_q; // 0: clock high half, 1: clock low half
	logic tick;
	logic sclk_q, sync_q, data_q;
	logic woke_q;

	assign link.sclk = sclk_q;
	assign link.sync_n = sync_q;
	assign link.sdata = data_q;
	assign tick = div_q == 3'(SCLK_HALF_CYC - 1);

	// half-period enable divider
	always_ff @(posedge mclk) begin
		if (!reset_n || state_q != ST_SHIFT) begin
			div_q <= 3'h0;
		end else begin
			div_q <= tick ? 3'h0 : div_q + 3'h1;
		end
	end

	// frame sequencer; clock idles high, data changes on rising edge
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			frame_q <= 24'h000000;
			bit_q <= 5'h00;
			wait_q <= 10'h000;
			phase_q <= 1'b0;
			sclk_q <= 1'b1;
			sync_q <= 1'b1;
			data_q <= 1'b0;
			req_ready <= 1'b0;
			woke_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					req_ready <= 1'b1;
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						frame_q <= {6'h00, req_mode, req_code};
						woke_q <= req_mode == MODE_NORMAL;
						sync_q <= 1'b0;
						data_q <= 1'b0; // leading bits are ignored, idle low
						bit_q <= 5'h00;
						phase_q <= 1'b0;
						state_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (tick) begin
						phase_q <= ~phase_q;
						if (!phase_q) begin
							sclk_q <= 1'b0;
						end else if (bit_q == LAST_BIT_IDX) begin
							sclk_q <= 1'b1;
							sync_q <= 1'b1;
							wait_q <= 10'h000;
							state_q <= ST_GAP;
						end else begin
							sclk_q <= 1'b1;
							bit_q <= bit_q + 5'h01;
							data_q <= frame_q[5'(LAST_BIT_IDX - 5'(bit_q + 5'h01))];
						end
					end else if (!phase_q && div_q == 3'h0 && sclk_q) begin
						data_q <= frame_q[5'(LAST_BIT_IDX - bit_q)];
					end
				end
				ST_GAP: begin
					wait_q <= wait_q + 10'h001;
					if (wait_q == 10'(SYNC_HIGH_CYC)) begin
						wait_q <= 10'h000;
						state_q <= woke_q ? ST_WAKE : ST_IDLE;
					end
				end
				ST_WAKE: begin
					wait_q <= wait_q + 10'h001;
					if (wait_q == 10'(WAKE_CYC - 1)) begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// output valid once wake time passed after a normal-mode frame
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			out_valid <= 1'b0;
		end else if (state_q == ST_SHIFT) begin
			out_valid <= 1'b0;
		end else if (state_q == ST_WAKE && wait_q == 10'(WAKE_CYC - 1)) begin
			out_valid <= 1'b1;
		end
	end
endmodule

// [tb/dacsw_asserts.sv]
`timescale 1ns/100ps
module dacsw_asserts
	import dacsw_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// link wires
	input wire logic sync_n,
	input wire logic sclk,
	input wire logic sdata,
	// device side
	input wire logic [15:0] dac_code,
	input wire logic [1:0] op_mode,
	input wire logic amp_to_output,
	input wire logic term_1k,
	input wire logic term_100k,
	input wire logic term_hiz,
	input wire logic shutdown_bias,
	input wire logic shutdown_amp,
	input wire logic shutdown_string,
	input wire logic frame_abort
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic sclk_q;
	logic [4:0] falls_q;
	// falling sclk edges in the open frame
	always_ff @(posedge mclk) begin
		sclk_q <= sclk;
	end
	always_ff @(posedge mclk) begin
		if (!reset_n || sync_n) begin
			falls_q <= 5'h00;
		end else if (sclk_q && !sclk) begin
			falls_q <= falls_q + 5'h01;
		end
	end
	chk_frame_falls: assert property ($rose(sync_n) |-> falls_q == 5'h18) else $error("bad edge count");
	chk_sync_gap: assert property ($rose(sync_n) |-> sync_n[*5]) else $error("sync gap short");
	chk_sclk_idle: assert property (sync_n |-> sclk) else $error("sclk moves outside frame");
	chk_data_stable: assert property ($fell(sclk) |-> $stable(sdata)) else $error("data moves at fall");
	chk_abort_keeps: assert property (frame_abort |-> ($stable(dac_code) && $stable(op_mode))[*2])
		else $error("abort changed state");
	chk_pd_shutdown: assert property (op_mode != MODE_NORMAL |=> shutdown_bias && shutdown_amp
		&& shutdown_string && !amp_to_output) else $error("no shutdown");
	chk_term_select: assert property ({term_1k, term_100k, term_hiz} == {$past(op_mode) == MODE_PD_1K,
		$past(op_mode) == MODE_PD_100K, $past(op_mode) == MODE_PD_HIZ}) else $error("bad termination");
	chk_amp_route: assert property (amp_to_output == ($past(op_mode) == MODE_NORMAL)) else $error("bad route");
	// main scenarios reached
	cover property (frame_abort);
	cover property (op_mode == MODE_PD_HIZ);
	cover property ($fell(sync_n));
endmodule

// [tb/dac_serial_write_powerdown_test.sv]
`timescale 1ns/100ps
module dac_serial_write_powerdown_test;
	import dacsw_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic req_valid = 1'b0;
	logic [1:0] req_mode = 2'h0;
	logic [15:0] req_code = 16'h0000;
	logic req_ready, out_valid, amp, t1k, t100k, thiz, sb, sa, ss, done, abort, abort_b;
	logic ab_seen = 1'b0;
	logic [15:0] code, code_b;
	logic [1:0] mode, mode_b;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	dacsw_if link();
	dacsw_if link_b();
	dacsw_host u_dacsw_host (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req_mode(req_mode),
		.req_code(req_code), .req_ready(req_ready), .out_valid(out_valid), .link(link));
	dacsw_dev u_dacsw_dev (.mclk(mclk), .reset_n(reset_n), .link(link), .dac_code(code), .op_mode(mode),
		.amp_to_output(amp), .term_1k(t1k), .term_100k(t100k), .term_hiz(thiz), .shutdown_bias(sb),
		.shutdown_amp(sa), .shutdown_string(ss), .frame_done(done), .frame_abort(abort));
	// second end on a link the bench drives, for faults
	dacsw_dev #(.POR_MIDSCALE(1'b1)) u_dacsw_dev_b (.mclk(mclk), .reset_n(reset_n), .link(link_b),
		.dac_code(code_b), .op_mode(mode_b), .amp_to_output(), .term_1k(), .term_100k(), .term_hiz(),
		.shutdown_bias(), .shutdown_amp(), .shutdown_string(), .frame_done(), .frame_abort(abort_b));
	dacsw_asserts u_dacsw_asserts (.mclk(mclk), .reset_n(reset_n), .sync_n(link.sync_n), .sclk(link.sclk),
		.sdata(link.sdata), .dac_code(code), .op_mode(mode), .amp_to_output(amp), .term_1k(t1k),
		.term_100k(t100k), .term_hiz(thiz), .shutdown_bias(sb), .shutdown_amp(sa),
		.shutdown_string(ss), .frame_abort(abort));
	always #4 mclk = ~mclk;
	// watchdog: run needs under two thousand cycles, so 20000 means a hang
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (abort_b === 1'b1) ab_seen <= 1'b1;
		if (cyc == 20000) begin
			failures++;
			complete_run();
		end
	end
	task complete_run;
		if (failures == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task check(input logic [17:0] got, input logic [17:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_for(ref logic s, input int lim);
		for (int i = 0; i < lim && s !== 1'b1; i++) @(posedge mclk);
	endtask
	// one request through the host end, then judge the far end
	task write(input logic [1:0] m, input logic [15:0] c);
		wait_for(req_ready, 1000);
		req_valid <= 1'b1;
		req_mode <= m;
		req_code <= c;
		@(posedge mclk);
		req_valid <= 1'b0;
		wait_for(done, 400);
		repeat (3) @(posedge mclk);
		check({mode, code}, {m, c});
		check({11'h000, amp, t1k, t100k, thiz, sb, sa, ss}, {11'h000, m == MODE_NORMAL, m == MODE_PD_1K,
			m == MODE_PD_100K, m == MODE_PD_HIZ, {3{m != MODE_NORMAL}}});
	endtask
	task power_on;
		check({mode, code}, {MODE_NORMAL, CODE_ZERO});
		check({mode_b, code_b}, {MODE_NORMAL, CODE_MID});
	endtask
	task modes;
		int n;
		write(MODE_PD_1K, 16'hffff);
		write(MODE_PD_100K, 16'h0001);
		write(MODE_PD_HIZ, 16'h8001);
		write(MODE_NORMAL, 16'h7ffe);
		for (n = 0; n < WAKE_CYC + 50 && out_valid !== 1'b1; n++) @(posedge mclk);
		check({17'h00000, n >= WAKE_CYC - 20 && out_valid === 1'b1}, 18'h00001);
	endtask
	// link clock of 64 ns, data moved while sclk is high
	task drive_bit(input logic b);
		link_b.sclk <= 1'b1;
		link_b.sdata <= b;
		repeat (4) @(posedge mclk);
		link_b.sclk <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
	task send_b(input logic [27:0] f, input int n);
		link_b.sync_n <= 1'b0;
		repeat (4) @(posedge mclk);
		for (int k = n - 1; k >= 0; k--) drive_bit(f[k]);
		link_b.sclk <= 1'b1;
		link_b.sdata <= ~link_b.sdata;
		repeat (4) @(posedge mclk);
		link_b.sync_n <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask
	// short frame, then a frame with four extra edges
	task abort_test;
		send_b(28'h00003ff, 10);
		check({17'h00000, ab_seen}, 18'h00001);
		check({mode_b, code_b}, {MODE_NORMAL, CODE_MID});
		send_b({6'h3f, MODE_PD_1K, 16'h5a5a, 4'hf}, 28);
		check({mode_b, code_b}, {MODE_PD_1K, 16'h5a5a});
	endtask
	initial begin
		link_b.sync_n = 1'b1;
		link_b.sclk = 1'b1;
		link_b.sdata = 1'b0;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		power_on;
		abort_test;
		modes;
		complete_run;
	end
endmodule
